// >>> verilog/dlc_params.svh
// constants for the latency compliance control block
`ifndef DLC_PARAMS_SVH
`define DLC_PARAMS_SVH

`define DLC_OFS_CTL 8'h82
`define DLC_OFS_MSTAT_LO 8'h6A
`define DLC_OFS_MSTAT_HI 8'h6B
`define DLC_CTL_RESET 8'h00
`define DLC_CTL_WMASK 8'h0F
`define DLC_BIT_RETRY 7
`define DLC_BIT_SERRF 7
`define DLC_DISCARD_CLKS 32768
`define DLC_TGT_LIMIT_CLKS 16
`define DLC_IRDY_LIMIT_CLKS 8

`endif

// >>> verilog/dlc_pkg.sv
// types for the latency compliance control block
`default_nettype none
package dlc_pkg;

	typedef struct packed {
		logic [3:0] rsvd;
		logic serr_en;
		logic usb_passive_release_en;
		logic passive_release_en;
		logic delayed_txn_en;
	} dlc_ctl_t;

	typedef enum logic [1:0] {
		DT_EMPTY,
		DT_ISSUED,
		DT_READY,
		DT_DIRECT
	} dlc_dt_state_t;

endpackage
`default_nettype wire

// >>> verilog/dlc_ctl.sv
// latency compliance control: delayed transactions and passive release
//
// Functional notes
// - as target, answer TRDY or STOP within 16 clocks of FRAME; the code does so only with bit 0 set, a direct cycle waits for ISA_DONE
// - as master, assert IRDY within 8 clocks in every data phase
// - ISA-bound target cycles are served by delayed completion
// - discard timer expires after more than 2^15 clocks without retry
// - control bit 0 turns delayed transactions on or off
// - control bit 1 turns passive release on bus hold request
// - control bit 2 allows passive release for USB traffic
// - control bit 3 lets discard expiry raise SERR
// - no guaranteed access time mode while passive release is on
// - ISA master accesses to PCI memory may be held off long
// - SERR from discard expiry sets a flag, cleared by writing one
// - host retry option works only with delayed and passive enabled
`timescale 1ns/1ps
`default_nettype none
`include "dlc_params.svh"

module dlc_ctl #(
	parameter int KEY_W = 32,
	parameter int DISCARD_CLKS = `DLC_DISCARD_CLKS
) (
	input wire logic MCLK,
	input wire logic RST_B,
	input wire logic CFG_WR,
	input wire logic CFG_RD,
	input wire logic [7:0] CFG_ADDR,
	input wire logic [7:0] CFG_WDATA,
	output logic [7:0] CFG_RDATA,
	input wire logic TGT_START,
	input wire logic [KEY_W-1:0] TGT_KEY,
	input wire logic TGT_HOST,
	output logic TGT_TRDY,
	output logic TGT_STOP,
	output logic ISA_START,
	input wire logic ISA_DONE,
	input wire logic MST_START,
	input wire logic MST_USB,
	input wire logic MST_DPHASE,
	input wire logic MST_END,
	output logic MST_IRDY,
	output logic BUS_HOLD_REQUEST_N,
	input wire logic ISA_MST_REQ,
	input wire logic ISA_MST_DONE,
	input wire logic GAT_REQ,
	output logic ISA_IOCHRDY,
	output logic GUARANTEED_ACCESS_TIME_MODE,
	output logic SERR_N
);

	if (KEY_W < 1 || DISCARD_CLKS < 2)
	begin : g_bad_param
		$error("dlc_ctl: bad parameter");
	end

	localparam int TW = $clog2(DISCARD_CLKS + 2);

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	dlc_pkg::dlc_ctl_t ctl;
	logic retry_en;
	logic serr_flag;
	logic discard;

	wire wr_ctl = CFG_WR && CFG_ADDR == `DLC_OFS_CTL;
	wire wr_lo = CFG_WR && CFG_ADDR == `DLC_OFS_MSTAT_LO;
	wire wr_hi = CFG_WR && CFG_ADDR == `DLC_OFS_MSTAT_HI;
	// set beats a simultaneous write-one clear
	wire next_serr_flag = (discard && ctl.serr_en) ||
		(serr_flag && !(wr_hi && CFG_WDATA[`DLC_BIT_SERRF]));

	always_ff @(posedge MCLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			ctl <= `DLC_CTL_RESET;
			retry_en <= 1'b0;
			serr_flag <= 1'b0;
		end
		else
		begin
			if (wr_ctl)
				ctl <= CFG_WDATA & `DLC_CTL_WMASK;
			if (wr_lo)
				retry_en <= CFG_WDATA[`DLC_BIT_RETRY];
			serr_flag <= next_serr_flag;
		end
	end

	wire [7:0] rd_mux = (CFG_ADDR == `DLC_OFS_CTL) ? ctl :
		(CFG_ADDR == `DLC_OFS_MSTAT_LO) ? {retry_en, 7'h00} :
		(CFG_ADDR == `DLC_OFS_MSTAT_HI) ? {serr_flag, 7'h00} : 8'h00;

	always_ff @(posedge MCLK or negedge RST_B)
	begin
		if (!RST_B)
			CFG_RDATA <= 8'h00;
		else if (CFG_RD)
			CFG_RDATA <= rd_mux;
	end

	// ------------------------------------------------------------
	// target side: delayed transaction entry
	// ------------------------------------------------------------
	dlc_pkg::dlc_dt_state_t st;
	dlc_pkg::dlc_dt_state_t next_st;
	logic [KEY_W-1:0] key;
	logic [TW-1:0] idle_cnt;

	wire pending = st == dlc_pkg::DT_ISSUED || st == dlc_pkg::DT_READY;
	wire hit = pending && TGT_KEY == key;
	// host retry without queuing: needs both mechanisms on, nothing pending
	wire host_retry = retry_en && ctl.delayed_txn_en &&
		ctl.passive_release_en && TGT_HOST && !pending;
	// a direct cycle still in flight must not be overtaken by a queued one
	wire new_dt = TGT_START && ctl.delayed_txn_en &&
		st == dlc_pkg::DT_EMPTY && !host_retry;
	wire new_direct = TGT_START && !ctl.delayed_txn_en &&
		st == dlc_pkg::DT_EMPTY;
	wire complete = TGT_START && hit && st == dlc_pkg::DT_READY;
	wire expire = pending && idle_cnt == TW'(DISCARD_CLKS);
	assign discard = expire && !complete;

	always_comb
	begin
		next_st = st;
		unique case (st)
			dlc_pkg::DT_EMPTY:
				if (new_dt)
					next_st = dlc_pkg::DT_ISSUED;
				else if (new_direct)
					next_st = dlc_pkg::DT_DIRECT;
			dlc_pkg::DT_ISSUED:
				if (discard)
					next_st = dlc_pkg::DT_EMPTY;
				else if (ISA_DONE)
					next_st = dlc_pkg::DT_READY;
			dlc_pkg::DT_READY:
				if (complete || discard)
					next_st = dlc_pkg::DT_EMPTY;
			dlc_pkg::DT_DIRECT:
				if (ISA_DONE)
					next_st = dlc_pkg::DT_EMPTY;
		endcase
	end

	// any retry of the queued request restarts the discard count
	wire [TW-1:0] next_idle_cnt = (!pending || (TGT_START && hit)) ?
		'0 : (expire ? idle_cnt : idle_cnt + TW'(1));

	always_ff @(posedge MCLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			st <= dlc_pkg::DT_EMPTY;
			key <= '0;
			idle_cnt <= '0;
		end
		else
		begin
			st <= next_st;
			if (new_dt)
				key <= TGT_KEY;
			idle_cnt <= next_idle_cnt;
		end
	end

	// STOP and completion TRDY come one clock after the request is seen; direct-cycle TRDY one clock after ISA_DONE
	wire next_stop = TGT_START && ctl.delayed_txn_en && !complete;
	wire next_trdy = complete || (st == dlc_pkg::DT_DIRECT && ISA_DONE);

	always_ff @(posedge MCLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			TGT_STOP <= 1'b0;
			TGT_TRDY <= 1'b0;
			ISA_START <= 1'b0;
			SERR_N <= 1'b1;
		end
		else
		begin
			TGT_STOP <= next_stop;
			TGT_TRDY <= next_trdy;
			ISA_START <= new_dt || new_direct;
			SERR_N <= !(discard && ctl.serr_en);
		end
	end

	// ------------------------------------------------------------
	// master side: passive release and ISA master hold-off
	// ------------------------------------------------------------
	wire pr_use = ctl.passive_release_en &&
		(!MST_USB || ctl.usb_passive_release_en);
	logic mst_busy;
	logic isa_wait;

	// passive release marks its start with a one-clock release pulse
	wire next_hold_n = !(mst_busy || MST_START) ||
		(MST_START && pr_use);
	wire next_isa_wait = ctl.passive_release_en &&
		(ISA_MST_REQ || isa_wait) && !ISA_MST_DONE;

	always_ff @(posedge MCLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			mst_busy <= 1'b0;
			MST_IRDY <= 1'b0;
			BUS_HOLD_REQUEST_N <= 1'b1;
			isa_wait <= 1'b0;
		end
		else
		begin
			mst_busy <= (mst_busy || MST_START) && !MST_END;
			MST_IRDY <= MST_DPHASE;
			BUS_HOLD_REQUEST_N <= next_hold_n;
			isa_wait <= next_isa_wait;
		end
	end

	assign ISA_IOCHRDY = !isa_wait;
	assign GUARANTEED_ACCESS_TIME_MODE =
		GAT_REQ && !ctl.passive_release_en;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	AST_TGT_ANSWER: assert property (@(posedge MCLK) disable iff (!RST_B)
		TGT_START && ctl.delayed_txn_en |=> TGT_STOP || TGT_TRDY)
		else $error("target answer late");
	AST_IRDY: assert property (@(posedge MCLK) disable iff (!RST_B)
		MST_DPHASE |-> ##[1:8] MST_IRDY)
		else $error("irdy late");
	AST_DT_QUEUE: assert property (@(posedge MCLK) disable iff (!RST_B)
		new_dt |=> ISA_START && st == dlc_pkg::DT_ISSUED)
		else $error("delayed request not queued");
	AST_DISCARD: assert property (@(posedge MCLK) disable iff (!RST_B)
		pending && idle_cnt == TW'(DISCARD_CLKS) && !TGT_START
		|=> st == dlc_pkg::DT_EMPTY)
		else $error("discard timer missed");
	AST_NO_DT: assert property (@(posedge MCLK) disable iff (!RST_B)
		!ctl.delayed_txn_en && TGT_START |=> !TGT_STOP)
		else $error("delayed txn while disabled");
	AST_USB_PR: assert property (@(posedge MCLK) disable iff (!RST_B)
		MST_START && MST_USB && !ctl.usb_passive_release_en
		|=> !BUS_HOLD_REQUEST_N)
		else $error("usb passive release while disabled");
	AST_SERR: assert property (@(posedge MCLK) disable iff (!RST_B)
		discard && ctl.serr_en |=> !SERR_N && serr_flag)
		else $error("serr not raised on expiry");
	AST_NO_SERR: assert property (@(posedge MCLK) disable iff (!RST_B)
		!$past(ctl.serr_en) |-> SERR_N)
		else $error("serr while disabled");
	AST_GAT: assert property (@(posedge MCLK) disable iff (!RST_B)
		ctl.passive_release_en |-> !GUARANTEED_ACCESS_TIME_MODE)
		else $error("gat with passive release");
	AST_FLAG_HOLD: assert property (@(posedge MCLK) disable iff (!RST_B)
		serr_flag && !wr_hi |=> serr_flag)
		else $error("flag lost");
	AST_HOST_RETRY: assert property (@(posedge MCLK) disable iff (!RST_B)
		host_retry && TGT_START |=> TGT_STOP && !ISA_START)
		else $error("host retry queued a txn");

endmodule

`default_nettype wire

// >>> verif/dlc_isa_model.sv
// ISA side model: finishes each started cycle after a fixed wait
`timescale 1ns/1ps
`default_nettype none
module dlc_isa_model #(
	parameter int WAIT = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	output logic done
);
	int cnt;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= 0;
			done <= 1'b0;
		end
		else
		begin
			done <= (cnt == 1);
			if (start)
				cnt <= WAIT;
			else if (cnt != 0)
				cnt <= cnt - 1;
		end
	end
endmodule
`default_nettype wire

// >>> verif/dlc_ctl_tb_top.sv
// self-checking bench for the latency compliance control block
`timescale 1ns/1ps
`default_nettype none
module dlc_ctl_tb_top;
	logic clk = 0, rst_b = 0, wr = 0, rd = 0, ts = 0, th = 0;
	logic ms = 0, mu = 0, md = 0, me = 0, iq = 0, id = 0, guaranteed_access_time_mode = 1;
	logic [7:0] a = 0, wd = 0, rdat;
	logic [31:0] key = 0;
	logic trdy, stp, isa, idone, irdy, hold, iordy, gm, serr_n;
	logic st, tr, is;
	localparam int DISCARD = 20;
	int errors = 0, checked = 0, n;
	logic [31:0] rows [6] = '{32'h1055_8200, 32'h82FF_820F,
		32'h8200_1000, 32'h6A80_6A80, 32'h6B80_6B00, 32'h6A00_6A00};
	logic [11:0] mrows [6] = '{12'h021, 12'h000, 12'h022, 12'h0E3,
		12'h042, 12'h002};
	dlc_ctl #(.DISCARD_CLKS(DISCARD)) u_dut (.MCLK(clk), .RST_B(rst_b),
		.CFG_WR(wr), .CFG_RD(rd), .CFG_ADDR(a), .CFG_WDATA(wd),
		.CFG_RDATA(rdat), .TGT_START(ts), .TGT_KEY(key), .TGT_HOST(th),
		.TGT_TRDY(trdy), .TGT_STOP(stp), .ISA_START(isa),
		.ISA_DONE(idone), .MST_START(ms), .MST_USB(mu), .MST_DPHASE(md),
		.MST_END(me), .MST_IRDY(irdy), .BUS_HOLD_REQUEST_N(hold),
		.ISA_MST_REQ(iq), .ISA_MST_DONE(id), .GAT_REQ(guaranteed_access_time_mode),
		.ISA_IOCHRDY(iordy), .GUARANTEED_ACCESS_TIME_MODE(gm),
		.SERR_N(serr_n));
	dlc_isa_model u_isa (.clk(clk), .rst_n(rst_b), .start(isa),
		.done(idone));
	initial
	begin
		forever #5 clk = ~clk;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		checked++;
		if (g !== e)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic nc(int k);
		repeat (k) @(negedge clk);
	endtask
	task automatic cw(logic [7:0] ad, logic [7:0] d);
		a = ad;
		wd = d;
		wr = 1;
		nc(1);
		wr = 0;
		nc(1);
	endtask
	task automatic cr(logic [7:0] ad, logic [7:0] e);
		a = ad;
		rd = 1;
		nc(1);
		rd = 0;
		chk("rdata", e, rdat);
		nc(1);
	endtask
	// one target cycle; answer flags are taken in the cycle after start
	task automatic tgt(logic [31:0] k, logic h);
		key = k;
		th = h;
		ts = 1;
		nc(1);
		ts = 0;
		st = stp;
		tr = trdy;
		is = isa;
		nc(1);
	endtask
	task automatic stop_test;
		if (errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		#100000;
		errors++;
		stop_test;
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		nc(3);
		chk("hold", 1, hold);
		chk("serr", 1, serr_n);
		chk("iordy", 1, iordy);
		rst_b = 1;
		foreach (rows[i])
		begin
			cw(rows[i][31:24], rows[i][23:16]);
			cr(rows[i][15:8], rows[i][7:0]);
		end
		cw(8'h6A, 8'h80);
		cw(8'h82, 8'h03);
		tgt(32'hA0, 1);
		chk("host stop", 1, st);
		chk("host isa", 0, is);
		cw(8'h6A, 8'h00);
		cw(8'h82, 8'h0B);
		tgt(32'hA1, 0);
		chk("stop", 1, st);
		chk("isa", 1, is);
		tgt(32'hA2, 0);
		chk("busy isa", 0, is);
		nc(8);
		tgt(32'hA1, 0);
		chk("trdy", 1, tr);
		tgt(32'hA1, 0);
		chk("new isa", 1, is);
		n = 0;
		while (serr_n !== 0 && n < 60)
		begin
			nc(1);
			n++;
		end
		chk("serr low", 0, serr_n);
		chk("late", DISCARD, n);
		cr(8'h6B, 8'h80);
		cw(8'h6B, 8'h80);
		cr(8'h6B, 8'h00);
		tgt(32'hA1, 0);
		chk("drop isa", 1, is);
		cw(8'h82, 8'h03);
		n = 0;
		repeat (50)
		begin
			nc(1);
			n += !serr_n;
		end
		chk("no serr", 0, n);
		cr(8'h6B, 8'h00);
		cw(8'h82, 8'h00);
		tgt(32'hA3, 0);
		chk("direct stop", 0, st);
		n = 0;
		while (trdy !== 1 && n < 20)
		begin
			nc(1);
			n++;
		end
		chk("direct trdy", 1, trdy);
		foreach (mrows[i])
		begin
			cw(8'h82, mrows[i][11:4]);
			chk("gat", !mrows[i][5], gm);
			mu = mrows[i][1];
			ms = 1;
			nc(1);
			ms = 0;
			chk("hold c1", mrows[i][0], hold);
			nc(1);
			chk("hold c2", 0, hold);
			md = 1;
			nc(1);
			md = 0;
			chk("irdy", 1, irdy);
			me = 1;
			nc(1);
			me = 0;
			nc(2);
			chk("hold end", 1, hold);
		end
		guaranteed_access_time_mode = 0;
		nc(1);
		chk("gat idle", 0, gm);
		cw(8'h82, 8'h02);
		iq = 1;
		nc(1);
		iq = 0;
		nc(4);
		chk("iordy wait", 0, iordy);
		id = 1;
		nc(1);
		id = 0;
		nc(1);
		chk("iordy ready", 1, iordy);
		cw(8'h82, 8'h00);
		iq = 1;
		nc(1);
		iq = 0;
		nc(1);
		chk("iordy no pr", 1, iordy);
		stop_test;
	end
endmodule
`default_nettype wire
